// >>> hw/drc_ramp_carrier.sv
// Ramp generator, carrier derating, direction and motor set selection with register port
//
// Our own choices: the address map and the strobed register port.
`timescale 1ns/1ps
module drc_ramp_carrier
  import drc_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = RAMP_QUANTUM_CYC
)
(
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  input  wire drc_bus_req_t bus_in,
  output logic [15:0]       rdata_out,
  input  wire logic         up_key_in,
  input  wire logic         down_key_in,
  input  wire logic         heatsink_hot_in,
  input  wire logic         motor_term_in,
  input  wire logic         motor_term_assigned_in,
  input  wire logic         freq_src_digital_in,
  input  wire logic [9:0]   pct_ref_in,
  output logic [15:0]       freq_out,
  output logic [15:0]       carrier_out,
  output logic              dir_reverse_out,
  output logic              active_motor_set_out
);

  typedef struct packed {
    logic        unit;
    logic [15:0] accel1;
    logic [15:0] decel1;
    logic [15:0] accel2;
    logic [15:0] decel2;
    logic [15:0] car_set;
    logic        ref_sel;
    logic        ud_sel;
    logic        therm;
    logic        mset;
    logic        dir;
    logic        vec1;
    logic        vec2;
    logic [15:0] max_freq;
    logic [15:0] set_freq;
    logic [15:0] rdata;
    logic [1:0]  up_s;
    logic [1:0]  dn_s;
    logic [1:0]  hot_s;
    logic [1:0]  term_s;
    logic        up_d;
    logic        dn_d;
    logic        act_set;
    logic [17:0] tick_cnt;
    logic [5:0]  min_cnt;
    logic [6:0]  der_cnt;
    drc_div_st_t div_st;
    logic [4:0]  div_cnt;
    logic [16:0] div_rem;
    logic [31:0] div_quot;
    logic [31:0] div_dvd;
    logic [15:0] div_ref;
    logic [15:0] div_time;
    logic [31:0] step;
    logic [31:0] out_q;
    logic [15:0] car_eff;
  } drc_state_t;

  drc_state_t s;
  drc_state_t next_s;

  logic        up_ev;
  logic        dn_ev;
  logic        act;
  logic        vec_act;
  logic [15:0] acc_t;
  logic [15:0] dec_t;
  logic [15:0] target;
  logic [15:0] ramp_ref;
  logic [31:0] tgt32;
  logic        rising;
  logic [15:0] ramp_t;
  logic        quantum;
  logic        ramp_tick;
  logic        der_tick;
  logic [15:0] car_lo;
  logic [15:0] car_hi;
  logic [15:0] car_prog;
  logic [31:0] pct_freq;
  logic [16:0] rem_sh;
  logic [16:0] ud_sum;
  logic [15:0] ud_base;

  // Software-visible settings back to their factory values
  function automatic drc_state_t drc_defaults(input drc_state_t x);
    drc_state_t y;
    y          = x;
    y.unit     = RST_UNIT;
    y.accel1   = RST_RAMP_TIME;
    y.decel1   = RST_RAMP_TIME;
    y.accel2   = RST_RAMP_TIME;
    y.decel2   = RST_RAMP_TIME;
    y.car_set  = RST_CARRIER;
    y.ref_sel  = RST_REF_SEL;
    y.ud_sel   = RST_UD_SEL;
    y.therm    = RST_THERM;
    y.mset     = RST_MSET;
    y.dir      = 1'b0;
    y.vec1     = 1'b0;
    y.vec2     = 1'b0;
    y.max_freq = RST_MAX_FREQ;
    y.set_freq = RST_SET_FREQ;
    return y;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    next_s       = s;
    next_s.rdata = 16'h0000;
    next_s.up_s   = {s.up_s[0], up_key_in};
    next_s.dn_s   = {s.dn_s[0], down_key_in};
    next_s.hot_s  = {s.hot_s[0], heatsink_hot_in};
    next_s.term_s = {s.term_s[0], motor_term_in};
    next_s.up_d   = s.up_s[1];
    next_s.dn_d   = s.dn_s[1];
    up_ev = s.up_s[1] & ~s.up_d;
    dn_ev = s.dn_s[1] & ~s.dn_d;

    // Terminal wins over the setting when it is assigned
    act = motor_term_assigned_in ? s.term_s[1] : s.mset;
    next_s.act_set = act;
    vec_act = act ? s.vec2 : s.vec1;
    acc_t   = act ? s.accel2 : s.accel1;
    dec_t   = act ? s.decel2 : s.decel1;

    pct_freq = (32'(pct_ref_in) * 32'(s.max_freq)) / PCT_FULL;
    target   = freq_src_digital_in ? s.set_freq : pct_freq[15:0];
    // Above 100 percent the product can overflow 16 bits, so a nonzero upper half also clamps the slice
    if (target > s.max_freq || (!freq_src_digital_in && pct_freq[31:16] != 16'h0000))
      target = s.max_freq;
    ramp_ref = s.ref_sel ? target : s.max_freq;
    tgt32    = {target, 16'h0000};
    rising   = s.out_q < tgt32;
    ramp_t   = rising ? acc_t : dec_t;

    // Time base: one ramp tick is 0.01 of the selected unit
    quantum = s.tick_cnt == 18'(TICK_CYCLES - 1);
    next_s.tick_cnt = quantum ? 18'h00000 : s.tick_cnt + 18'h00001;
    if (quantum)
      next_s.min_cnt = (s.min_cnt == MINUTE_QUANTA - 6'h01) ? 6'h00 : s.min_cnt + 6'h01;
    ramp_tick = quantum && (s.unit == UNIT_SEC || s.min_cnt == MINUTE_QUANTA - 6'h01);
    der_tick  = quantum && s.der_cnt == DERATE_QUANTA - 7'h01;
    if (quantum)
      next_s.der_cnt = der_tick ? 7'h00 : s.der_cnt + 7'h01;

    // Serial divider: slope = reference / time, started again from idle after any operand change
    rem_sh = {s.div_rem[15:0], s.div_dvd[31]};
    case (s.div_st)
      DIV_IDLE:
      begin
        if (ramp_ref != s.div_ref || ramp_t != s.div_time)
        begin
          next_s.div_ref  = ramp_ref;
          next_s.div_time = ramp_t;
          next_s.div_dvd  = {ramp_ref, 16'h0000};
          next_s.div_rem  = 17'h00000;
          next_s.div_quot = 32'h0000_0000;
          next_s.div_cnt  = 5'h00;
          next_s.div_st   = DIV_RUN;
        end
      end
      DIV_RUN:
      begin
        next_s.div_dvd = {s.div_dvd[30:0], 1'b0};
        if (rem_sh >= {1'b0, s.div_time})
        begin
          next_s.div_rem  = rem_sh - {1'b0, s.div_time};
          next_s.div_quot = {s.div_quot[30:0], 1'b1};
        end
        else
        begin
          next_s.div_rem  = rem_sh;
          next_s.div_quot = {s.div_quot[30:0], 1'b0};
        end
        next_s.div_cnt = s.div_cnt + 5'h01;
        if (s.div_cnt == 5'h1f)
          next_s.div_st = DIV_DONE;
      end
      DIV_DONE:
      begin
        next_s.step   = s.div_quot;
        next_s.div_st = DIV_IDLE;
      end
      default:
        next_s.div_st = DIV_IDLE;
    endcase

    // Ramp: fixed point 16.16; a stale slope is used until the divider finishes
    if (ramp_tick)
    begin
      if (rising)
      begin
        if (ramp_t == 16'h0000 || (tgt32 - s.out_q) <= s.step)
          next_s.out_q = tgt32;
        else
          next_s.out_q = s.out_q + s.step;
      end
      else if (s.out_q > tgt32)
      begin
        if (ramp_t == 16'h0000 || (s.out_q - tgt32) <= s.step)
          next_s.out_q = tgt32;
        else
          next_s.out_q = s.out_q - s.step;
      end
    end

    // Carrier window depends on control method of the active set
    car_lo   = vec_act ? CAR_VEC_MIN : CAR_MIN;
    car_hi   = vec_act ? CAR_VEC_MAX : CAR_MAX;
    car_prog = s.car_set;
    if (car_prog < car_lo)
      car_prog = car_lo;
    if (car_prog > car_hi)
      car_prog = car_hi;
    if (!s.therm)
      next_s.car_eff = car_prog;
    else if (der_tick)
    begin
      if (s.hot_s[1])
        next_s.car_eff = (s.car_eff > car_lo + CAR_STEP) ? s.car_eff - CAR_STEP : car_lo;
      else
        next_s.car_eff = (s.car_eff + CAR_STEP < car_prog) ? s.car_eff + CAR_STEP : car_prog;
    end
    // Setting lowered or method changed while derated
    if (next_s.car_eff > car_prog)
      next_s.car_eff = car_prog;
    if (next_s.car_eff < car_lo)
      next_s.car_eff = car_lo;

    // Up/down step only for the digital source; a bus write below takes priority
    ud_base = s.ud_sel ? s.set_freq : s.out_q[31:16];
    ud_sum  = {1'b0, ud_base} + {1'b0, UPDOWN_STEP};
    if (freq_src_digital_in && up_ev)
      next_s.set_freq = (ud_sum > {1'b0, s.max_freq}) ? s.max_freq : ud_sum[15:0];
    else if (freq_src_digital_in && dn_ev)
      next_s.set_freq = (ud_base > UPDOWN_STEP) ? ud_base - UPDOWN_STEP : 16'h0000;

    ////////////////////////////////////////////////////////////////////////////
    if (bus_in.wr)
    begin
      if (bus_in.addr == ADR_UNIT)
        next_s.unit = bus_in.wdata[0];
      else if (bus_in.addr == ADR_ACCEL1)
        next_s.accel1 = bus_in.wdata;
      else if (bus_in.addr == ADR_DECEL1)
        next_s.decel1 = bus_in.wdata;
      else if (bus_in.addr == ADR_CARRIER)
        next_s.car_set = bus_in.wdata;
      else if (bus_in.addr == ADR_REF_SEL)
        next_s.ref_sel = bus_in.wdata[0];
      else if (bus_in.addr == ADR_UD_SEL)
        next_s.ud_sel = bus_in.wdata[0];
      else if (bus_in.addr == ADR_THERM)
        next_s.therm = bus_in.wdata[0];
      else if (bus_in.addr == ADR_MSET)
        next_s.mset = bus_in.wdata[0];
      else if (bus_in.addr == ADR_CTRL)
        {next_s.vec2, next_s.vec1, next_s.dir} = bus_in.wdata[2:0];
      else if (bus_in.addr == ADR_MAX_FREQ)
        next_s.max_freq = bus_in.wdata;
      else if (bus_in.addr == ADR_SET_FREQ)
        next_s.set_freq = bus_in.wdata;
      else if (bus_in.addr == ADR_ACCEL2)
        next_s.accel2 = bus_in.wdata;
      else if (bus_in.addr == ADR_DECEL2)
        next_s.decel2 = bus_in.wdata;
      else if (bus_in.addr == ADR_CMD && bus_in.wdata[0])
        next_s = drc_defaults(next_s);
    end
    if (bus_in.rd)
    begin
      if (bus_in.addr == ADR_UNIT)
        next_s.rdata = {15'h0000, s.unit};
      else if (bus_in.addr == ADR_ACCEL1)
        next_s.rdata = s.accel1;
      else if (bus_in.addr == ADR_DECEL1)
        next_s.rdata = s.decel1;
      else if (bus_in.addr == ADR_CARRIER)
        next_s.rdata = s.car_set;
      else if (bus_in.addr == ADR_REF_SEL)
        next_s.rdata = {15'h0000, s.ref_sel};
      else if (bus_in.addr == ADR_UD_SEL)
        next_s.rdata = {15'h0000, s.ud_sel};
      else if (bus_in.addr == ADR_THERM)
        next_s.rdata = {15'h0000, s.therm};
      else if (bus_in.addr == ADR_MSET)
        next_s.rdata = {15'h0000, s.mset};
      else if (bus_in.addr == ADR_CTRL)
        next_s.rdata = {13'h0000, s.vec2, s.vec1, s.dir};
      else if (bus_in.addr == ADR_MAX_FREQ)
        next_s.rdata = s.max_freq;
      else if (bus_in.addr == ADR_SET_FREQ)
        next_s.rdata = s.set_freq;
      else if (bus_in.addr == ADR_ACCEL2)
        next_s.rdata = s.accel2;
      else if (bus_in.addr == ADR_DECEL2)
        next_s.rdata = s.decel2;
      else if (bus_in.addr == ADR_STATUS)
        next_s.rdata = {12'h000, s.div_st != DIV_IDLE, s.act_set, vec_act, s.hot_s[1]};
      else if (bus_in.addr == ADR_OUT_FREQ)
        next_s.rdata = s.out_q[31:16];
      else if (bus_in.addr == ADR_CAR_EFF)
        next_s.rdata = s.car_eff;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      s         <= drc_defaults('0);
      s.car_eff <= RST_CARRIER;
    end
    else
      s <= next_s;
  end

  assign rdata_out            = s.rdata;
  assign freq_out             = s.out_q[31:16];
  assign carrier_out          = s.car_eff;
  assign dir_reverse_out      = s.dir;
  assign active_motor_set_out = s.act_set;

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  sequence s_rise_tick;
    ramp_tick && rising;
  endsequence
  sequence s_zero_accel;
    s_rise_tick ##0 (acc_t == 16'h0000);
  endsequence
  sequence s_up_from_set;
    freq_src_digital_in && up_ev && s.ud_sel && !bus_in.wr
      && ({1'b0, s.set_freq} + {1'b0, UPDOWN_STEP} <= {1'b0, s.max_freq});
  endsequence

  chk_carrier_range: assert property (carrier_out >= CAR_MIN && carrier_out <= CAR_MAX)
    else $error("carrier outside programmable range");
  chk_vector_window: assert property ($past(vec_act) && vec_act |->
      carrier_out >= CAR_VEC_MIN && carrier_out <= CAR_VEC_MAX)
    else $error("carrier outside vector window");
  chk_thermal_off: assert property (!s.therm |=> carrier_out == $past(car_prog))
    else $error("carrier moved without thermal adjust");
  chk_carrier_recover: assert property (s.therm && der_tick && !s.hot_s[1]
      && s.car_eff < car_prog && !bus_in.wr |=> carrier_out > $past(carrier_out))
    else $error("carrier not restored when cool");
  chk_init_dir: assert property (bus_in.wr && bus_in.addr == ADR_CMD && bus_in.wdata[0]
      |=> !dir_reverse_out && s.ref_sel == RST_REF_SEL)
    else $error("factory init left direction inverted");
  chk_term_wins: assert property (motor_term_assigned_in
      |=> active_motor_set_out == $past(s.term_s[1]))
    else $error("terminal selection not honoured");
  chk_set_select: assert property (!motor_term_assigned_in
      |=> active_motor_set_out == $past(s.mset))
    else $error("motor set setting not honoured");
  chk_updown_ignore: assert property ((up_ev || dn_ev) && !freq_src_digital_in
      && !bus_in.wr |=> $stable(s.set_freq))
    else $error("up/down acted on non-digital source");
  chk_updown_base: assert property (s_up_from_set
      |=> s.set_freq == $past(s.set_freq) + UPDOWN_STEP)
    else $error("up step not based on set frequency");
  chk_ramp_rise: assert property (s_rise_tick |=> freq_out >= $past(freq_out))
    else $error("output fell while accelerating");
  chk_zero_time: assert property (s_zero_accel |=> s.out_q == $past(tgt32))
    else $error("zero ramp time did not jump");

endmodule

// >>> shared/drc_pkg.sv
// Package: register map, reset values and timing constants for the ramp/carrier block
// Summary of operation
// - Ramp time unit: seconds or minutes
// - Accel time: zero to ramp reference
// - Decel time: ramp reference down to zero
// - Reference select: 0 max, 1 set frequency
// - Recompute slope whenever set frequency changes while reference select is 1
// - Carrier programmable 0.5 to 16.0 kHz
// - Vector control limits carrier 1.5-8.0 kHz
// - Direction bit inverts rotation, like phase swap
// - Factory initialisation clears direction inversion
// - Up/down base only for digital source
// - Up/down from running or set frequency
// - Thermal adjust lowers carrier when hot
// - Carrier restored stepwise once cool again
// - Motor set select: 0 first, 1 second
// - Assigned terminal overrides motor set setting
// - Each motor set keeps own settings; here only accel, decel and control method are per set, the rest is shared
// - Percent reference: 100.0 percent equals maximum
package drc_pkg;
  localparam int unsigned CLK_PERIOD_NS    = 40;
  localparam int unsigned RAMP_QUANTUM_NS  = 10_000_000;
  localparam int unsigned RAMP_QUANTUM_CYC = RAMP_QUANTUM_NS / CLK_PERIOD_NS;
  localparam logic [5:0]  MINUTE_QUANTA    = 6'h3c;
  localparam logic [6:0]  DERATE_QUANTA    = 7'h64;
  localparam logic [15:0] CAR_MIN          = 16'h0005;
  localparam logic [15:0] CAR_MAX          = 16'h00a0;
  localparam logic [15:0] CAR_VEC_MIN      = 16'h000f;
  localparam logic [15:0] CAR_VEC_MAX      = 16'h0050;
  localparam logic [15:0] CAR_STEP         = 16'h0005;
  localparam logic [15:0] UPDOWN_STEP      = 16'h000a;
  localparam logic [31:0] PCT_FULL         = 32'h0000_03e8;
  localparam logic        UNIT_SEC         = 1'b1;
  localparam logic        RST_UNIT         = 1'b1;
  localparam logic        RST_REF_SEL      = 1'b0;
  localparam logic        RST_UD_SEL       = 1'b0;
  localparam logic        RST_THERM        = 1'b0;
  localparam logic        RST_MSET         = 1'b0;
  localparam logic [15:0] RST_RAMP_TIME    = 16'h03e8;
  localparam logic [15:0] RST_CARRIER      = 16'h0028;
  localparam logic [15:0] RST_MAX_FREQ     = 16'h1388;
  localparam logic [15:0] RST_SET_FREQ     = 16'h1388;
  localparam logic [4:0]  ADR_UNIT         = 5'h00;
  localparam logic [4:0]  ADR_ACCEL1       = 5'h01;
  localparam logic [4:0]  ADR_DECEL1       = 5'h02;
  localparam logic [4:0]  ADR_CARRIER      = 5'h03;
  localparam logic [4:0]  ADR_REF_SEL      = 5'h04;
  localparam logic [4:0]  ADR_UD_SEL       = 5'h05;
  localparam logic [4:0]  ADR_THERM        = 5'h06;
  localparam logic [4:0]  ADR_MSET         = 5'h07;
  localparam logic [4:0]  ADR_CTRL         = 5'h08;
  localparam logic [4:0]  ADR_MAX_FREQ     = 5'h09;
  localparam logic [4:0]  ADR_SET_FREQ     = 5'h0a;
  localparam logic [4:0]  ADR_ACCEL2       = 5'h0b;
  localparam logic [4:0]  ADR_DECEL2       = 5'h0c;
  localparam logic [4:0]  ADR_CMD          = 5'h0d;
  localparam logic [4:0]  ADR_STATUS       = 5'h0e;
  localparam logic [4:0]  ADR_OUT_FREQ     = 5'h0f;
  localparam logic [4:0]  ADR_CAR_EFF      = 5'h10;

  typedef enum logic [1:0] {DIV_IDLE = 2'b00, DIV_RUN = 2'b01, DIV_DONE = 2'b11} drc_div_st_t;

  typedef struct packed {
    logic [4:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } drc_bus_req_t;
endpackage

// >>> sim/drc_motor_model.sv
// Heat sink model of the driven motor stage: heats under heavy load, hot flag with hysteresis
`timescale 1ns/1ps
module drc_motor_model
(
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic heavy_load_in,
  output logic      heatsink_hot_out
);
  logic [5:0] temp;

  // Hysteresis keeps the flag from chattering at one threshold
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      temp             <= 6'h00;
      heatsink_hot_out <= 1'b0;
    end
    else
    begin
      if (heavy_load_in && temp != 6'h3f)
        temp <= temp + 6'h01;
      else if (!heavy_load_in && temp != 6'h00)
        temp <= temp - 6'h01;
      if (temp >= 6'h30)
        heatsink_hot_out <= 1'b1;
      else if (temp <= 6'h10)
        heatsink_hot_out <= 1'b0;
    end
  end
endmodule

// >>> sim/test_drive_ramp_carrier_config.sv
// Self-checking bench for the ramp, carrier, direction and motor set block
`timescale 1ns/1ps
`define CHK(nm, exp, act) \
  begin \
    n_compared++; \
    if ((act) !== (exp)) \
    begin \
      failures++; \
      $display("[ERR] %s expected %h seen %h", nm, exp, act); \
    end \
  end
module test_drive_ramp_carrier_config;
  import drc_pkg::*;
  localparam int unsigned TICK = 4;
  logic         clk_in;
  logic         rst_in;
  drc_bus_req_t bus_in;
  logic [15:0]  rdata_out;
  logic         up_key_in;
  logic         down_key_in;
  logic         heatsink_hot;
  logic         motor_term_in;
  logic         motor_term_assigned_in;
  logic         freq_src_digital_in;
  logic [9:0]   pct_ref_in;
  logic [15:0]  freq_out;
  logic [15:0]  carrier_out;
  logic         dir_reverse_out;
  logic         active_motor_set_out;
  logic         heavy_load;
  int           failures;
  int           n_compared;

  drc_ramp_carrier #(.TICK_CYCLES(TICK)) uut (
    .clk_in(clk_in), .rst_in(rst_in), .bus_in(bus_in), .rdata_out(rdata_out),
    .up_key_in(up_key_in), .down_key_in(down_key_in), .heatsink_hot_in(heatsink_hot),
    .motor_term_in(motor_term_in), .motor_term_assigned_in(motor_term_assigned_in),
    .freq_src_digital_in(freq_src_digital_in), .pct_ref_in(pct_ref_in),
    .freq_out(freq_out), .carrier_out(carrier_out), .dir_reverse_out(dir_reverse_out),
    .active_motor_set_out(active_motor_set_out));

  drc_motor_model motor (.clk_in(clk_in), .rst_in(rst_in), .heavy_load_in(heavy_load),
    .heatsink_hot_out(heatsink_hot));

  initial
  begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  task automatic bw(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk_in);
    bus_in <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_in);
    bus_in.wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rchk(input string nm, input logic [4:0] a, input logic [15:0] exp);
    @(posedge clk_in);
    bus_in <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk_in);
    bus_in.rd <= 1'b0;
    @(negedge clk_in);
    `CHK(nm, exp, rdata_out)
    @(posedge clk_in);
  endtask

  // Pin held long enough to pass the input synchroniser
  task automatic key(input logic up);
    @(posedge clk_in);
    if (up)
      up_key_in <= 1'b1;
    else
      down_key_in <= 1'b1;
    wt(6);
    up_key_in   <= 1'b0;
    down_key_in <= 1'b0;
    wt(6);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rchk("unit", ADR_UNIT, 16'h0001);
    rchk("accel1", ADR_ACCEL1, RST_RAMP_TIME);
    rchk("ref sel", ADR_REF_SEL, 16'h0000);
    rchk("ud sel", ADR_UD_SEL, 16'h0000);
    rchk("therm", ADR_THERM, 16'h0000);
    rchk("mset", ADR_MSET, 16'h0000);
    rchk("unmapped", 5'h1f, 16'h0000);
    bw(ADR_CAR_EFF, 16'h0077);
    rchk("car eff", ADR_CAR_EFF, RST_CARRIER);
  endtask

  task automatic t_ramp();
    bw(ADR_ACCEL1, 16'h0000);
    bw(ADR_DECEL1, 16'h0000);
    bw(ADR_SET_FREQ, 16'h0000);
    wt(60);
    `CHK("jump zero", 16'h0000, freq_out)
    bw(ADR_ACCEL1, 16'h000a);
    bw(ADR_DECEL1, 16'h000a);
    wt(60);
    bw(ADR_SET_FREQ, 16'h1388);
    wt(20);
    `CHK("accel part", 1'b1, freq_out > 16'h0000 && freq_out < 16'h1388)
    wt(200);
    `CHK("accel end", 16'h1388, freq_out)
    bw(ADR_SET_FREQ, 16'h0000);
    wt(20);
    `CHK("decel part", 1'b1, freq_out > 16'h0000 && freq_out < 16'h1388)
    wt(200);
    `CHK("decel end", 16'h0000, freq_out)
  endtask

  task automatic t_unit();
    bw(ADR_UNIT, 16'h0000);
    wt(60);
    bw(ADR_SET_FREQ, 16'h1388);
    wt(400);
    `CHK("minute part", 1'b1, freq_out <= 16'h03e8)
    wt(2600);
    `CHK("minute end", 16'h1388, freq_out)
    bw(ADR_UNIT, 16'h0001);
    bw(ADR_SET_FREQ, 16'h0000);
    wt(300);
    `CHK("back zero", 16'h0000, freq_out)
  endtask

  task automatic t_ref();
    bw(ADR_REF_SEL, 16'h0001);
    bw(ADR_SET_FREQ, 16'h03e8);
    wt(200);
    `CHK("ref set end", 16'h03e8, freq_out)
    bw(ADR_SET_FREQ, 16'h07d0);
    wt(12);
    `CHK("ref set slope", 1'b1, freq_out < 16'h07d0)
    wt(200);
    `CHK("ref set end2", 16'h07d0, freq_out)
    bw(ADR_REF_SEL, 16'h0000);
  endtask

  task automatic t_carrier();
    logic [15:0] tbl [6][3];
    tbl = '{'{16'h0002, 16'h0000, 16'h0005}, '{16'h0100, 16'h0000, 16'h00a0},
            '{16'h0064, 16'h0000, 16'h0064}, '{16'h0002, 16'h0002, 16'h000f},
            '{16'h0100, 16'h0002, 16'h0050}, '{16'h0100, 16'h0004, 16'h00a0}};
    for (int i = 0; i < 6; i++)
    begin
      bw(ADR_CARRIER, tbl[i][0]);
      bw(ADR_CTRL, tbl[i][1]);
      wt(4);
      `CHK("carrier", tbl[i][2], carrier_out)
    end
    bw(ADR_MSET, 16'h0001);
    wt(4);
    `CHK("carrier set2", 16'h0050, carrier_out)
    bw(ADR_MSET, 16'h0000);
    bw(ADR_CTRL, 16'h0000);
    bw(ADR_CARRIER, 16'h0028);
    wt(4);
    rchk("car eff", ADR_CAR_EFF, 16'h0028);
  endtask

  task automatic t_thermal();
    heavy_load <= 1'b1;
    wt(600);
    `CHK("fixed carrier", 16'h0028, carrier_out)
    bw(ADR_THERM, 16'h0001);
    wt(500);
    `CHK("derated", 1'b1, carrier_out < 16'h0028)
    wt(3500);
    `CHK("derate floor", CAR_MIN, carrier_out)
    heavy_load <= 1'b0;
    wt(500);
    `CHK("restoring", 1'b1, carrier_out < 16'h0028)
    wt(3500);
    `CHK("restored", 16'h0028, carrier_out)
    bw(ADR_THERM, 16'h0000);
  endtask

  task automatic t_dir();
    bw(ADR_CTRL, 16'h0001);
    wt(2);
    `CHK("dir rev", 1'b1, dir_reverse_out)
    bw(ADR_UNIT, 16'h0000);
    bw(ADR_CMD, 16'h0001);
    wt(2);
    `CHK("dir init", 1'b0, dir_reverse_out)
    rchk("ctrl init", ADR_CTRL, 16'h0000);
    rchk("unit init", ADR_UNIT, 16'h0001);
  endtask

  task automatic t_mset();
    bw(ADR_MSET, 16'h0001);
    wt(2);
    `CHK("set2", 1'b1, active_motor_set_out)
    // Slope divider restarted by factory init must go idle first
    wt(40);
    rchk("status set", ADR_STATUS, {13'h0000, 1'b1, 2'b00} & 16'h0004);
    motor_term_assigned_in <= 1'b1;
    wt(6);
    `CHK("term wins", 1'b0, active_motor_set_out)
    bw(ADR_MSET, 16'h0000);
    motor_term_in <= 1'b1;
    wt(6);
    `CHK("term set2", 1'b1, active_motor_set_out)
    motor_term_assigned_in <= 1'b0;
    wt(2);
    `CHK("set1", 1'b0, active_motor_set_out)
  endtask

  task automatic t_updown();
    bw(ADR_ACCEL1, 16'h0000);
    bw(ADR_DECEL1, 16'h0000);
    bw(ADR_SET_FREQ, 16'h0800);
    wt(60);
    bw(ADR_UNIT, 16'h0000);
    bw(ADR_ACCEL1, 16'h7530);
    // Slope settles now, so no stale jump step survives into the up ramp
    bw(ADR_DECEL1, 16'h7530);
    wt(60);
    bw(ADR_SET_FREQ, 16'h1000);
    key(1'b1);
    rchk("up run base", ADR_SET_FREQ, 16'h080a);
    bw(ADR_UD_SEL, 16'h0001);
    key(1'b1);
    rchk("up set base", ADR_SET_FREQ, 16'h0814);
    key(1'b0);
    rchk("down set base", ADR_SET_FREQ, 16'h080a);
    freq_src_digital_in <= 1'b0;
    key(1'b1);
    rchk("not digital", ADR_SET_FREQ, 16'h080a);
    bw(ADR_UNIT, 16'h0001);
    bw(ADR_ACCEL1, 16'h0000);
    bw(ADR_DECEL1, 16'h0000);
    pct_ref_in <= 10'h1f4;
    wt(60);
    `CHK("pct half", 16'h09c4, freq_out)
    pct_ref_in <= 10'h3e8;
    wt(60);
    `CHK("pct full", 16'h1388, freq_out)
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    failures               = 0;
    n_compared             = 0;
    rst_in                 = 1'b1;
    bus_in                 = '0;
    up_key_in              = 1'b0;
    down_key_in            = 1'b0;
    heavy_load             = 1'b0;
    motor_term_in          = 1'b0;
    motor_term_assigned_in = 1'b0;
    freq_src_digital_in    = 1'b1;
    pct_ref_in             = 10'h3e8;
    wt(12);
    `CHK("rst freq", 16'h0000, freq_out)
    `CHK("rst carrier", RST_CARRIER, carrier_out)
    `CHK("rst dir", 1'b0, dir_reverse_out)
    `CHK("rst set", 1'b0, active_motor_set_out)
    rst_in <= 1'b0;
    wt(4);
    t_regs();
    t_ramp();
    t_unit();
    t_ref();
    t_carrier();
    t_thermal();
    t_dir();
    t_mset();
    t_updown();
    stop_test();
  end

  // Whole run needs about 13500 cycles
  initial
  begin
    wt(60000);
    failures++;
    $display("[ERR] watchdog expected done seen hang");
    stop_test();
  end
endmodule
